// [hdl/memory_map_consts.svh]
`ifndef MEMORY_MAP_CONSTS_SVH
`define MEMORY_MAP_CONSTS_SVH

// Region bounds of the 64 Kbyte space
`define IO_LO 16'h0000
`define IO_HI 16'h007f
`define DIR_RAM_LO 16'h0090
`define DIR_RAM_HI 16'h00ff
`define GPR_LO 16'h0100
`define GPR_HI 16'h01ff
`define XIO_LO 16'h0f80
`define XIO_HI 16'h0fff
`define NVR_LO 16'hffbb
`define NVR_HI 16'hffbf
`define VEC_LO 16'hffc0
`define VEC_HI 16'hffff
// Banked direct window
`define BANK_OP_LO 8'h80
`define BANK_BASE 16'h0100
`define BANK_SPAN_SHIFT 7
`define BANK_TOP_SMALL 16'h028f
`define BANK_TOP_LARGE 16'h047f
`define BANK_PTR_RESET 3'h0
// Default RAM top and flash base of the build
`define RAM_TOP_DEFAULT 16'h047f
`define FLASH_LO_DEFAULT 16'h8000

`endif

// [hdl/memory_map_pkg.sv]
package memory_map_pkg;
  // Region a decoded address falls into
  typedef enum logic [3:0] {
    region_io,
    region_xio,
    region_ram_dir,
    region_ram_gpr,
    region_ram,
    region_flash,
    region_nvr,
    region_vector,
    region_none
  } region_t;

  // Addressing mode of a core access
  typedef enum logic [1:0] {
    mode_full,
    mode_direct,
    mode_gpr
  } access_mode_t;

  // Reset pin states
  typedef enum logic [1:0] {
    pin_por_reset,
    pin_reset_io,
    pin_gp_port
  } pin_state_t;
endpackage : memory_map_pkg

// [hdl/direct_bank_xlate.sv]
`include "memory_map_consts.svh"
// ------------------------------------------------------------
// Direct operand translation
// ------------------------------------------------------------
module direct_bank_xlate
  import memory_map_pkg::*;
(
  input wire logic [7:0] operand,
  input wire logic [2:0] direct_bank_pointer,
  input wire logic large_ram,
  output logic [15:0] bank_addr,
  output logic bank_over
);
  logic [15:0] top;

  // Low operands and pointer zero pass through; others land in 128-byte banks
  always_comb begin
    top = large_ram ? `BANK_TOP_LARGE : `BANK_TOP_SMALL;
    if (operand < `BANK_OP_LO || direct_bank_pointer == 3'h0) begin
      bank_addr = {8'h00, operand};
    end else begin
      bank_addr = `BANK_BASE
        + ({13'h0000, direct_bank_pointer - 3'h1} << `BANK_SPAN_SHIFT)
        + {9'h000, operand[6:0]};
    end
    bank_over = bank_addr > top;
  end
endmodule : direct_bank_xlate

// [hdl/reset_pin_ctrl.sv]
// ------------------------------------------------------------
// Shared reset pin control
// ------------------------------------------------------------
module reset_pin_ctrl
  import memory_map_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic config_written,
  input wire logic reset_output_enable,
  input wire logic reset_pin_function_select,
  input wire logic internal_reset,
  input wire logic port_out,
  input wire logic port_oe,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic ext_reset,
  output logic port_in
);
  pin_state_t state;
  pin_state_t next_state;

  // Pin starts as reset in/out; configuration picks its later use
  always_comb begin
    next_state = state;
    if (config_written) begin
      next_state = reset_pin_function_select ? pin_reset_io : pin_gp_port;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= pin_por_reset;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Open-drain style reset output drives low while internal reset is held; once configured, only if reset_output_enable is set
  always_comb begin
    pin_out = 1'b0;
    pin_oe = 1'b0;
    ext_reset = 1'b0;
    port_in = 1'b0;
    case (state)
      pin_por_reset: begin
        pin_oe = internal_reset;
        ext_reset = !pin_in;
      end
      pin_reset_io: begin
        pin_oe = internal_reset && reset_output_enable;
        ext_reset = !pin_in;
      end
      pin_gp_port: begin
        pin_out = port_out;
        pin_oe = port_oe || (internal_reset && reset_output_enable);
        if (internal_reset && reset_output_enable) begin
          pin_out = 1'b0;
        end
        port_in = pin_in;
      end
      default: begin
        pin_oe = 1'b0;
      end
    endcase
  end
endmodule : reset_pin_ctrl

// [hdl/memory_map_bank_decoder.sv]
`include "memory_map_consts.svh"
// Operation
// - 0x0000-0x007F go to peripheral registers, memory and direct access.
// - 0x0F80-0x0FFF go to extended peripheral registers.
// - RAM 0x0090-0x00FF reachable by direct addressing.
// - 0x0100-0x01FF is RAM and also general-purpose registers.
// - 0xFFC0-0xFFFF is the vector table in flash.
// - 0xFFBB-0xFFBF holds non-volatile register data.
// - Direct operands 0x00-0x7F pass through regardless of bank pointer.
// - Bank pointer resets to zero; values 1-7 select 128-byte banks from 0x0100.
// - Banked top is 0x028F on small RAM, 0x047F otherwise.
// - Shared pin is reset I/O after power-on; config bits steer it.
// - The decoded space is 64 Kbyte; addresses in no region decode as region_none.
module memory_map_bank_decoder
  import memory_map_pkg::*;
#(
  parameter logic large_ram = 1'b1,
  parameter logic [15:0] ram_top = `RAM_TOP_DEFAULT,
  parameter logic [15:0] flash_lo = `FLASH_LO_DEFAULT
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic req,
  input wire logic [15:0] cpu_addr,
  input wire logic [1:0] cpu_mode,
  input wire logic [2:0] bank_ptr_wdata,
  input wire logic bank_ptr_we,
  input wire logic config_we,
  input wire logic reset_output_enable,
  input wire logic reset_pin_function_select,
  input wire logic internal_reset,
  input wire logic port_out,
  input wire logic port_oe,
  input wire logic shared_port_pin_in,
  input wire logic debug_mode_pin,
  output logic [15:0] phys_addr,
  output logic [3:0] region,
  output logic sel_io,
  output logic sel_xio,
  output logic sel_ram,
  output logic sel_gpr,
  output logic sel_flash,
  output logic sel_nvr,
  output logic sel_vector,
  output logic direct_ok,
  output logic bank_fault,
  output logic [2:0] direct_bank_pointer,
  output logic shared_port_pin_out,
  output logic shared_port_pin_oe,
  output logic ext_reset,
  output logic port_in,
  output logic debug_request
);
  // ------------------------------------------------------------
  // Decoding helpers
  // ------------------------------------------------------------

  // Inclusive range check, used for every region
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // Region lookup over the whole 16-bit space; anything unclaimed is region_none
  function automatic region_t classify(input logic [15:0] a);
    if (in_range(a, `IO_LO, `IO_HI)) begin
      classify = region_io;
    end else if (in_range(a, `XIO_LO, `XIO_HI)) begin
      classify = region_xio;
    end else if (in_range(a, `DIR_RAM_LO, `DIR_RAM_HI)) begin
      classify = region_ram_dir;
    end else if (in_range(a, `GPR_LO, `GPR_HI)) begin
      classify = region_ram_gpr;
    end else if (in_range(a, `GPR_HI + 16'h0001, ram_top)) begin
      classify = region_ram;
    end else if (in_range(a, `VEC_LO, `VEC_HI)) begin
      classify = region_vector;
    end else if (in_range(a, `NVR_LO, `NVR_HI)) begin
      classify = region_nvr;
    end else if (in_range(a, flash_lo, `NVR_LO - 16'h0001)) begin
      classify = region_flash;
    end else begin
      classify = region_none;
    end
  endfunction : classify

  // ------------------------------------------------------------
  // Direct bank pointer
  // ------------------------------------------------------------
  logic [2:0] next_direct_bank_pointer;

  always_comb begin
    next_direct_bank_pointer = direct_bank_pointer;
    if (bank_ptr_we) begin
      next_direct_bank_pointer = bank_ptr_wdata;
    end
  end

  // Pointer comes up at bank zero so direct operands map to themselves
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      direct_bank_pointer <= `BANK_PTR_RESET;
    end else if (ce) begin
      direct_bank_pointer <= next_direct_bank_pointer;
    end
  end

  // ------------------------------------------------------------
  // Address translation
  // ------------------------------------------------------------
  logic [15:0] bank_addr;
  logic bank_over;

  direct_bank_xlate u_xlate (
    .operand(cpu_addr[7:0]),
    .direct_bank_pointer(direct_bank_pointer),
    .large_ram(large_ram),
    .bank_addr(bank_addr),
    .bank_over(bank_over)
  );

  logic [15:0] eff_addr;
  logic eff_fault;
  region_t eff_region;

  // Only direct fetches are banked; a GPR fetch names a byte of 0x0100-0x01FF
  always_comb begin
    eff_fault = 1'b0;
    case (access_mode_t'(cpu_mode))
      mode_direct: begin
        eff_addr = bank_addr;
        eff_fault = bank_over;
      end
      mode_gpr: begin
        eff_addr = `GPR_LO | {8'h00, cpu_addr[7:0]};
      end
      mode_full: begin
        eff_addr = cpu_addr;
      end
      default: begin
        eff_addr = cpu_addr;
      end
    endcase
    eff_region = eff_fault ? region_none : classify(eff_addr);
  end

  // ------------------------------------------------------------
  // Registered decode outputs
  // ------------------------------------------------------------
  logic [15:0] next_phys_addr;
  region_t region_q;
  region_t next_region;
  logic next_fault;
  logic next_direct_ok;

  // Hold the last decode when no request is made, so the outputs stay stable
  always_comb begin
    next_phys_addr = phys_addr;
    next_region = region_q;
    next_fault = bank_fault;
    next_direct_ok = direct_ok;
    if (req) begin
      next_phys_addr = eff_addr;
      next_region = eff_region;
      next_fault = eff_fault;
      next_direct_ok = (eff_region == region_io) || (eff_region == region_ram_dir)
        || ((eff_region == region_ram_gpr || eff_region == region_ram)
            && (access_mode_t'(cpu_mode) == mode_direct));
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phys_addr <= 16'h0000;
      region_q <= region_none;
      bank_fault <= 1'b0;
      direct_ok <= 1'b0;
    end else if (ce) begin
      phys_addr <= next_phys_addr;
      region_q <= next_region;
      bank_fault <= next_fault;
      direct_ok <= next_direct_ok;
    end
  end

  // Selects follow the registered region; sel_ram also covers GPR and sel_flash also covers NVR and vectors
  always_comb begin
    region = region_q;
    sel_io = (region_q == region_io);
    sel_xio = (region_q == region_xio);
    sel_gpr = (region_q == region_ram_gpr);
    sel_ram = (region_q == region_ram_dir) || sel_gpr || (region_q == region_ram);
    sel_nvr = (region_q == region_nvr);
    sel_vector = (region_q == region_vector);
    sel_flash = (region_q == region_flash) || sel_nvr || sel_vector;
  end

  // ------------------------------------------------------------
  // Shared reset pin and debug pin
  // ------------------------------------------------------------
  reset_pin_ctrl u_pin (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .config_written(config_we),
    .reset_output_enable(reset_output_enable),
    .reset_pin_function_select(reset_pin_function_select),
    .internal_reset(internal_reset),
    .port_out(port_out),
    .port_oe(port_oe),
    .pin_in(shared_port_pin_in),
    .pin_out(shared_port_pin_out),
    .pin_oe(shared_port_pin_oe),
    .ext_reset(ext_reset),
    .port_in(port_in)
  );

  logic debug_q;
  logic next_debug_q;

  // Debug is only sampled once reset output is released; a low pin during reset
  // is the far side's fault and is deliberately not guarded here
  always_comb begin
    next_debug_q = debug_q;
    if (!internal_reset) begin
      next_debug_q = !debug_mode_pin;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      debug_q <= 1'b0;
    end else if (ce) begin
      debug_q <= next_debug_q;
    end
  end

  assign debug_request = debug_q;
endmodule : memory_map_bank_decoder

// [test/memory_map_bank_decoder_props.sv]
module memory_map_bank_decoder_props
  import memory_map_pkg::*;
#(
  parameter logic [15:0] ram_top = 16'h047f
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic req,
  input wire logic [15:0] cpu_addr,
  input wire logic [1:0] cpu_mode,
  input wire logic bank_ptr_we,
  input wire logic [2:0] bank_ptr_wdata,
  input wire logic [15:0] phys_addr,
  input wire logic [3:0] region,
  input wire logic bank_fault,
  input wire logic [2:0] direct_bank_pointer
);
  logic take;
  logic banked;
  logic [15:0] bank_exp;
  // Banked target: each pointer step moves the window by 128 bytes
  assign take = req && ce;
  assign banked = take && cpu_mode == 2'h1 && cpu_addr[7] && direct_bank_pointer != 3'h0;
  assign bank_exp = 16'h0080 + {6'h00, direct_bank_pointer, cpu_addr[6:0]};
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  full_addr_a: assert property (
    take && cpu_mode == 2'h0 |=> phys_addr == $past(cpu_addr)) else $error("full addr changed");
  io_route_a: assert property (
    take && cpu_mode == 2'h0 && cpu_addr <= 16'h007f |=> region == region_io)
    else $error("io window missed");
  xio_route_a: assert property (
    take && cpu_mode == 2'h0 && cpu_addr >= 16'h0f80 && cpu_addr <= 16'h0fff
    |=> region == region_xio) else $error("xio window missed");
  vector_route_a: assert property (
    take && cpu_mode == 2'h0 && cpu_addr >= 16'hffc0 |=> region == region_vector)
    else $error("vector table missed");
  direct_pass_a: assert property (
    take && cpu_mode == 2'h1 && !cpu_addr[7] |=> phys_addr == ($past(cpu_addr) & 16'h007f))
    else $error("low operand moved");
  bank_xlate_a: assert property (
    banked && bank_exp <= ram_top |=> phys_addr == $past(bank_exp) && !bank_fault)
    else $error("bank window wrong");
  bank_cap_a: assert property (
    banked && bank_exp > ram_top |=> bank_fault && region == region_none)
    else $error("bank cap missed");
  ptr_write_a: assert property (
    bank_ptr_we && ce |=> direct_bank_pointer == $past(bank_ptr_wdata))
    else $error("pointer not written");
  // Main scenarios reached
  banked_c: cover property (banked && bank_exp <= ram_top);
  fault_c: cover property (banked && bank_exp > ram_top);
  gpr_c: cover property (take && cpu_mode == 2'h2);
endmodule : memory_map_bank_decoder_props

// [test/core_side_model.sv]
// ------------------------------------------------------------
// Core side: presents one access per issue, plus the debug pin
// ------------------------------------------------------------
module core_side_model (
  input wire logic mclk,
  input wire logic issue,
  input wire logic [1:0] mode_in,
  input wire logic [15:0] addr_in,
  input wire logic dbg_low,
  input wire logic internal_reset,
  output logic req,
  output logic [1:0] cpu_mode,
  output logic [15:0] cpu_addr,
  output logic debug_mode_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    req = 1'h0;
    cpu_mode = 2'h0;
    cpu_addr = 16'h5a5a;
    debug_mode_pin = 1'h1;
  end
  // Idle address toggles so a stale value is never mistaken for a request
  always @(negedge mclk) begin
    req <= issue;
    cpu_mode <= mode_in;
    cpu_addr <= issue ? addr_in : ~cpu_addr;
    debug_mode_pin <= internal_reset ? 1'h1 : !dbg_low;
  end
endmodule : core_side_model

// [test/memory_map_bank_decoder_tb.sv]
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s: expected %h seen %h", n, e, g); end end
module memory_map_bank_decoder_tb
  import memory_map_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [1:0] m; logic [2:0] p; logic [15:0] a;} row_t;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic ce = 1'h1;
  logic issue = 1'h0;
  logic dbg_low = 1'h0;
  logic ext_low = 1'h0;
  logic [1:0] mode_in = 2'h0;
  logic [15:0] addr_in = 16'h0000;
  logic [2:0] bank_ptr_wdata = 3'h0;
  logic bank_ptr_we = 1'h0;
  logic config_we = 1'h0;
  logic reset_output_enable = 1'h1;
  logic reset_pin_function_select = 1'h1;
  logic internal_reset = 1'h1;
  logic port_out = 1'h0;
  logic port_oe = 1'h0;
  logic req, debug_mode_pin, shared_port_pin_in, bank_fault, shared_port_pin_out;
  logic shared_port_pin_oe, ext_reset, port_in, debug_request;
  logic sel_io, sel_xio, sel_ram, sel_gpr, sel_flash, sel_nvr, sel_vector, direct_ok;
  logic [1:0] cpu_mode;
  logic [15:0] cpu_addr, phys_addr;
  logic [3:0] region;
  logic [2:0] direct_bank_pointer;
  int miscompares = 0;
  int num_checks = 0;
  row_t rows [24] = '{'{2'h0, 3'h0, 16'h0000}, '{2'h0, 3'h0, 16'h007f}, '{2'h0, 3'h0, 16'h0f80},
    '{2'h0, 3'h0, 16'h0fff}, '{2'h0, 3'h0, 16'h0090}, '{2'h0, 3'h0, 16'h01ff},
    '{2'h0, 3'h3, 16'h0085}, '{2'h0, 3'h0, 16'h0300}, '{2'h0, 3'h0, 16'hffba},
    '{2'h0, 3'h0, 16'hffbb}, '{2'h0, 3'h0, 16'hffbf}, '{2'h0, 3'h0, 16'hffc0},
    '{2'h0, 3'h0, 16'hffff}, '{2'h0, 3'h0, 16'h7fff}, '{2'h1, 3'h5, 16'h0010},
    '{2'h1, 3'h7, 16'h127f}, '{2'h1, 3'h0, 16'h00ff}, '{2'h1, 3'h0, 16'h0085},
    '{2'h1, 3'h1, 16'h0085}, '{2'h1, 3'h2, 16'h00ff}, '{2'h1, 3'h4, 16'h008f},
    '{2'h1, 3'h4, 16'h0090}, '{2'h1, 3'h7, 16'h0080}, '{2'h2, 3'h6, 16'h0023}};
  // Pin has a pull-up; outside logic may pull it low
  assign shared_port_pin_in = shared_port_pin_oe ? shared_port_pin_out : !ext_low;
  memory_map_bank_decoder #(.large_ram(1'h0), .ram_top(16'h028f)) u_memory_map_bank_decoder (
    .mclk, .rst, .ce, .req, .cpu_addr, .cpu_mode, .bank_ptr_wdata, .bank_ptr_we, .config_we,
    .reset_output_enable, .reset_pin_function_select, .internal_reset, .port_out, .port_oe,
    .shared_port_pin_in, .debug_mode_pin, .phys_addr, .region, .sel_io, .sel_xio,
    .sel_ram, .sel_gpr, .sel_flash, .sel_nvr, .sel_vector, .direct_ok,
    .bank_fault, .direct_bank_pointer, .shared_port_pin_out, .shared_port_pin_oe, .ext_reset,
    .port_in, .debug_request);
  core_side_model u_core_side_model (.mclk, .issue, .mode_in, .addr_in, .dbg_low,
    .internal_reset, .req, .cpu_mode, .cpu_addr, .debug_mode_pin);
  initial begin
    forever #25 mclk = ~mclk;
  end
  // Region decode with the small-RAM top of this build
  function automatic logic [3:0] region_of(input logic [15:0] a);
    if (a <= 16'h007f) return region_io;
    if (a >= 16'h0f80 && a <= 16'h0fff) return region_xio;
    if (a >= 16'h0090 && a <= 16'h00ff) return region_ram_dir;
    if (a >= 16'h0100 && a <= 16'h01ff) return region_ram_gpr;
    if (a >= 16'h0200 && a <= 16'h028f) return region_ram;
    if (a >= 16'hffc0) return region_vector;
    if (a >= 16'hffbb) return region_nvr;
    if (a >= 16'h8000) return region_flash;
    return region_none;
  endfunction : region_of
  // Pointer write lands one edge before the access is taken
  task automatic run(input logic [1:0] m, input logic [2:0] p, input logic [15:0] a);
    logic [15:0] x;
    logic f;
    logic [3:0] r;
    logic [6:0] s;
    logic d;
    x = m == 2'h2 ? {8'h01, a[7:0]} : a;
    if (m == 2'h1) x = (a[7] && p != 3'h0) ? 16'h0080 + {6'h00, p, a[6:0]} : {8'h00, a[7:0]};
    f = m == 2'h1 && a[7] && p != 3'h0 && x > 16'h028f;
    r = f ? region_none : region_of(x);
    // Selects: RAM covers direct, GPR and plain RAM; flash covers its data, NVR and vectors
    s = {r == region_io, r == region_xio,
      r == region_ram_dir || r == region_ram_gpr || r == region_ram, r == region_ram_gpr,
      r == region_flash || r == region_nvr || r == region_vector, r == region_nvr,
      r == region_vector};
    d = r == region_io || r == region_ram_dir
      || (m == 2'h1 && (r == region_ram_gpr || r == region_ram));
    @(negedge mclk);
    bank_ptr_we <= 1'h1;
    bank_ptr_wdata <= p;
    issue <= 1'h1;
    mode_in <= m;
    addr_in <= a;
    @(negedge mclk);
    bank_ptr_we <= 1'h0;
    issue <= 1'h0;
    @(negedge mclk);
    `CHK("region", f ? region_none : region_of(x), region);
    if (!f) `CHK("phys_addr", x, phys_addr);
    `CHK("bank_fault", f, bank_fault);
    `CHK("selects", s, {sel_io, sel_xio, sel_ram, sel_gpr, sel_flash, sel_nvr, sel_vector});
    `CHK("direct_ok", d, direct_ok);
    `CHK("pointer", p, direct_bank_pointer);
  endtask : run
  task finish_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  initial begin
    #1000000;
    miscompares++;
    finish_test;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(negedge mclk);
    rst <= 1'h0;
    @(negedge mclk);
    `CHK("pin_oe", 1'h1, shared_port_pin_oe);
    `CHK("ext_reset", 1'h1, ext_reset);
    internal_reset <= 1'h0;
    @(negedge mclk);
    `CHK("pin_oe", 1'h0, shared_port_pin_oe);
    ext_low <= 1'h1;
    @(negedge mclk);
    `CHK("ext_reset", 1'h1, ext_reset);
    ext_low <= 1'h0;
    reset_pin_function_select <= 1'h0;
    config_we <= 1'h1;
    port_oe <= 1'h1;
    @(negedge mclk);
    config_we <= 1'h0;
    @(negedge mclk);
    `CHK("pin_oe", 1'h1, shared_port_pin_oe);
    `CHK("port_in", 1'h0, port_in);
    port_oe <= 1'h0;
    dbg_low <= 1'h1;
    @(negedge mclk);
    `CHK("port_in", 1'h1, port_in);
    `CHK("ext_reset", 1'h0, ext_reset);
    @(negedge mclk);
    `CHK("debug_request", 1'h1, debug_request);
    dbg_low <= 1'h0;
    $display("test pin done");
    foreach (rows[i]) begin
      run(rows[i].m, rows[i].p, rows[i].a);
    end
    $display("test table done");
    rst <= 1'h1;
    @(negedge mclk);
    rst <= 1'h0;
    `CHK("pointer", 3'h0, direct_bank_pointer);
    `CHK("region", region_none, region);
    $display("test reset done");
    finish_test;
  end
endmodule : memory_map_bank_decoder_tb
bind memory_map_bank_decoder memory_map_bank_decoder_props #(.ram_top(ram_top)) u_props (
  .mclk, .rst, .ce, .req, .cpu_addr, .cpu_mode, .bank_ptr_we, .bank_ptr_wdata, .phys_addr,
  .region, .bank_fault, .direct_bank_pointer);
